// >>> logic/tcm_channel.v
// One timer channel with its mode register, count value register and the
// shared four-bit output level and output enable registers.
// Assumes a simple strobe register port and a pin input synchronous to clock_i.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_defines.vh"

module tcm_channel (
	// Clock and reset
	input wire clock_i,
	input wire reset_n_i,
	// Register port
	input wire [`TCM_ADDR_W-1:0] addr_i,
	input wire [`TCM_DATA_W-1:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output wire [`TCM_DATA_W-1:0] rdata_o,
	// Timer pins
	input wire timer_input_pin_i,
	input wire [2:0] other_toggle_i,
	output wire [3:0] timer_out_o,
	// Status
	output wire timer_irq_o,
	output wire running_o
);

	// Channel states
	localparam ST_IDLE = 2'h0;
	localparam ST_ARMED = 2'h1;
	localparam ST_RUN = 2'h2;

	// Active count mask for the chosen width
	function [`TCM_DATA_W-1:0] cnt_mask;
		input split;
		begin
			cnt_mask = split ? `TCM_SPLIT_MASK : `TCM_FULL_MASK;
		end
	endfunction

	// Masked decrement, wraps inside the active width
	function [`TCM_DATA_W-1:0] cnt_dec;
		input [`TCM_DATA_W-1:0] v;
		input split;
		begin
			cnt_dec = (v - 16'h0001) & cnt_mask(split);
		end
	endfunction

	// Masked increment, wraps inside the active width
	function [`TCM_DATA_W-1:0] cnt_inc;
		input [`TCM_DATA_W-1:0] v;
		input split;
		begin
			cnt_inc = (v + 16'h0001) & cnt_mask(split);
		end
	endfunction

	// Zero test inside the active width
	function cnt_zero;
		input [`TCM_DATA_W-1:0] v;
		input split;
		begin
			cnt_zero = ((v & cnt_mask(split)) == 16'h0000);
		end
	endfunction

	reg [3:0] md_r;
	reg [1:0] edge_r;
	reg split_r;
	reg [`TCM_DATA_W-1:0] count_value_r;
	reg [3:0] out_level_r;
	reg [3:0] out_en_r;
	reg pin_trig_r;
	reg [`TCM_DATA_W-1:0] cnt_r;
	reg [`TCM_DATA_W-1:0] cnt_nxt;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg irq_r;
	reg irq_nxt;
	reg tog_nxt;
	reg cap_nxt;
	reg [`TCM_DATA_W-1:0] rdata_r;
	reg [`TCM_DATA_W-1:0] rdata_nxt;
	reg [3:0] level_nxt;
	reg valid_edge;
	reg start_edge;
	reg end_edge;
	integer i;

	wire pin_rise;
	wire pin_fall;
	wire [2:0] opmode;
	wire start_opt;
	wire sw_start;
	wire sw_stop;
	wire trig;
	wire running;
	wire [3:0] ch_tog;

	// Edge pulses from the input pin
	tcm_edge_detect u_edge (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.level_i(timer_input_pin_i),
		.rise_o(pin_rise),
		.fall_o(pin_fall)
	);

	// Mode fields and software strobes
	assign opmode = md_r[`TCM_MODE_OPMODE_MSB:`TCM_MODE_OPMODE_LSB];
	assign start_opt = md_r[`TCM_MODE_START_OPT];
	assign sw_start = wr_i && (addr_i == `TCM_OFS_CTRL) && wdata_i[`TCM_CTRL_START];
	assign sw_stop = wr_i && (addr_i == `TCM_OFS_CTRL) && wdata_i[`TCM_CTRL_STOP];
	assign running = (state_r == ST_RUN);

	// Valid edge decode; width modes start on one edge and end on the other
	always @* begin
		valid_edge = 1'b0;
		start_edge = 1'b0;
		end_edge = 1'b0;
		case (edge_r)
			`TCM_EDGE_FALL: valid_edge = pin_fall;
			`TCM_EDGE_RISE: valid_edge = pin_rise;
			`TCM_EDGE_LOW_W: begin
				valid_edge = pin_rise | pin_fall;
				start_edge = pin_fall;
				end_edge = pin_rise;
			end
			`TCM_EDGE_HIGH_W: begin
				valid_edge = pin_rise | pin_fall;
				start_edge = pin_rise;
				end_edge = pin_fall;
			end
			default: valid_edge = 1'b0;
		endcase
	end

	// A start comes from software, or in interval and one-count modes from a valid pin edge when enabled
	assign trig = sw_start | (pin_trig_r & valid_edge);

	// Counting engine; the count value must already be loaded at start
	always @* begin
		cnt_nxt = cnt_r;
		state_nxt = state_r;
		irq_nxt = 1'b0;
		tog_nxt = 1'b0;
		cap_nxt = 1'b0;
		if (sw_stop) begin
			state_nxt = ST_IDLE;
		end else begin
			case (opmode)
				`TCM_OPM_INTERVAL: begin
					if (trig) begin
						cnt_nxt = count_value_r & cnt_mask(split_r);
						state_nxt = ST_RUN;
						irq_nxt = start_opt;
						tog_nxt = start_opt;
					end else if (running) begin
						if (cnt_zero(cnt_r, split_r)) begin
							cnt_nxt = count_value_r & cnt_mask(split_r);
							irq_nxt = 1'b1;
							tog_nxt = 1'b1;
						end else begin
							cnt_nxt = cnt_dec(cnt_r, split_r);
						end
					end
				end
				`TCM_OPM_CAPTURE: begin
					if (sw_start) begin
						cnt_nxt = 16'h0000;
						state_nxt = ST_RUN;
						irq_nxt = start_opt;
						tog_nxt = start_opt;
					end else if (running) begin
						if (valid_edge) begin
							cap_nxt = 1'b1;
							cnt_nxt = 16'h0000;
							irq_nxt = 1'b1;
						end else begin
							cnt_nxt = cnt_inc(cnt_r, split_r);
						end
					end
				end
				`TCM_OPM_EVENT: begin
					// No start interrupt here; option bit is left unread
					if (sw_start) begin
						cnt_nxt = count_value_r & cnt_mask(split_r);
						state_nxt = ST_RUN;
					end else if (running && valid_edge) begin
						if (cnt_zero(cnt_r, split_r)) begin
							cnt_nxt = count_value_r & cnt_mask(split_r);
							irq_nxt = 1'b1;
							tog_nxt = 1'b1;
						end else begin
							cnt_nxt = cnt_dec(cnt_r, split_r);
						end
					end
				end
				`TCM_OPM_ONECOUNT: begin
					if (trig && !running) begin
						cnt_nxt = count_value_r & cnt_mask(split_r);
						state_nxt = ST_RUN;
						tog_nxt = 1'b1;
					end else if (trig && start_opt) begin
						cnt_nxt = count_value_r & cnt_mask(split_r);
						irq_nxt = 1'b1;
					end else if (running) begin
						// A trigger with option 0 falls through and is ignored
						if (cnt_zero(cnt_r, split_r)) begin
							state_nxt = ST_IDLE;
							irq_nxt = 1'b1;
							tog_nxt = 1'b1;
						end else begin
							cnt_nxt = cnt_dec(cnt_r, split_r);
						end
					end
				end
				`TCM_OPM_WIDTH: begin
					// Start option is ignored: no start interrupt, no retrigger
					if (sw_start) begin
						state_nxt = ST_ARMED;
					end else if (state_r == ST_ARMED && start_edge) begin
						cnt_nxt = 16'h0000;
						state_nxt = ST_RUN;
					end else if (running) begin
						if (end_edge) begin
							cap_nxt = 1'b1;
							irq_nxt = 1'b1;
							state_nxt = ST_ARMED;
						end else begin
							cnt_nxt = cnt_inc(cnt_r, split_r);
						end
					end
				end
				default: begin
					// Prohibited codes just hold the channel where it is
					state_nxt = state_r;
				end
			endcase
		end
	end

	// Counter, state and interrupt pulse
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r <= `TCM_RST_COUNT;
			state_r <= ST_IDLE;
			irq_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			state_r <= state_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Configuration registers written by software
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			md_r <= `TCM_RST_MODE;
			edge_r <= `TCM_RST_EDGE;
			split_r <= 1'b0;
			out_en_r <= `TCM_RST_OUT;
			pin_trig_r <= 1'b0;
		end else if (wr_i) begin
			if (addr_i == `TCM_OFS_MODE) begin
				md_r <= wdata_i[`TCM_MODE_OPMODE_MSB:`TCM_MODE_START_OPT];
				edge_r <= wdata_i[`TCM_MODE_EDGE_MSB:`TCM_MODE_EDGE_LSB];
				split_r <= wdata_i[`TCM_MODE_SPLIT];
			end
			if (addr_i == `TCM_OFS_OUT_ENABLE) begin
				out_en_r <= wdata_i[3:0];
			end
			if (addr_i == `TCM_OFS_CTRL) begin
				pin_trig_r <= wdata_i[`TCM_CTRL_PIN_TRIG];
			end
		end
	end

	// Count value: a capture beats a software write in the same cycle
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_value_r <= `TCM_RST_COUNT;
		end else if (cap_nxt) begin
			count_value_r <= cnt_r & cnt_mask(split_r);
		end else if (wr_i && (addr_i == `TCM_OFS_COUNT_VALUE)) begin
			count_value_r <= wdata_i;
		end
	end

	// Toggle requests per channel; channel 0 is this engine
	assign ch_tog = {other_toggle_i, tog_nxt};

	// Output bits: timer owns enabled bits, software owns the rest
	always @* begin
		level_nxt = out_level_r;
		for (i = 0; i < 4; i = i + 1) begin
			if (out_en_r[i]) begin
				if (ch_tog[i]) begin
					level_nxt[i] = ~out_level_r[i];
				end
			end else if (wr_i && (addr_i == `TCM_OFS_OUT_LEVEL)) begin
				level_nxt[i] = wdata_i[i];
			end
		end
	end

	// Output level register, four channel bits
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			out_level_r <= `TCM_RST_OUT;
		end else begin
			out_level_r <= level_nxt;
		end
	end

	// Read mux; unmapped offsets and unheld bits read as zero
	always @* begin
		rdata_nxt = 16'h0000;
		if (rd_i) begin
			case (addr_i)
				`TCM_OFS_MODE: rdata_nxt = {4'h0, split_r, 3'h0, edge_r, 2'h0, md_r};
				`TCM_OFS_COUNT_VALUE: rdata_nxt = count_value_r;
				`TCM_OFS_OUT_LEVEL: rdata_nxt = {12'h000, out_level_r};
				`TCM_OFS_OUT_ENABLE: rdata_nxt = {12'h000, out_en_r};
				`TCM_OFS_CTRL: rdata_nxt = {10'h000, state_r, 1'b0, pin_trig_r, 2'h0};
				`TCM_OFS_COUNTER: rdata_nxt = cnt_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	// Read data stands for exactly the cycle after the strobe
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Outputs; running_o is decoded from state_r, the rest are registered
	assign rdata_o = rdata_r;
	assign timer_out_o = out_level_r;
	assign timer_irq_o = irq_r;
	assign running_o = running;

endmodule // tcm_channel

`default_nettype wire

// >>> logic/tcm_defines.vh
// Constants for the timer channel: register offsets, field positions,
// reset values and operation mode codes.
// Assumes a 16-bit register port with byte addresses in word steps.
`ifndef TCM_DEFINES_VH
`define TCM_DEFINES_VH

// Register port geometry
`define TCM_ADDR_W 5
`define TCM_DATA_W 16

// Register byte offsets
`define TCM_OFS_MODE 5'h00
`define TCM_OFS_COUNT_VALUE 5'h04
`define TCM_OFS_OUT_LEVEL 5'h08
`define TCM_OFS_OUT_ENABLE 5'h0C
`define TCM_OFS_CTRL 5'h10
`define TCM_OFS_COUNTER 5'h14

// Mode register field positions
`define TCM_MODE_OPMODE_LSB 1
`define TCM_MODE_OPMODE_MSB 3
`define TCM_MODE_START_OPT 0
`define TCM_MODE_EDGE_LSB 6
`define TCM_MODE_EDGE_MSB 7
`define TCM_MODE_SPLIT 11

// Control register fields
`define TCM_CTRL_START 0
`define TCM_CTRL_STOP 1
`define TCM_CTRL_PIN_TRIG 2
`define TCM_CTRL_STATE_LSB 4

// Operation mode codes held in the upper three mode bits
`define TCM_OPM_INTERVAL 3'h0
`define TCM_OPM_CAPTURE 3'h2
`define TCM_OPM_EVENT 3'h3
`define TCM_OPM_ONECOUNT 3'h4
`define TCM_OPM_WIDTH 3'h6

// Input edge field codes
`define TCM_EDGE_FALL 2'h0
`define TCM_EDGE_RISE 2'h1
`define TCM_EDGE_LOW_W 2'h2
`define TCM_EDGE_HIGH_W 2'h3

// Reset values
`define TCM_RST_MODE 4'h0
`define TCM_RST_EDGE 2'h0
`define TCM_RST_COUNT 16'h0000
`define TCM_RST_OUT 4'h0

// Count width when the width select bit asks for 8-bit operation
`define TCM_SPLIT_MASK 16'h00FF
`define TCM_FULL_MASK 16'hFFFF

`endif

// >>> logic/tcm_edge_detect.v
// Edge detector for the timer input pin: one-cycle rise and fall pulses.
// Assumes the pin is already synchronous to clock_i.
`timescale 1ns/100ps
`default_nettype none

module tcm_edge_detect (
	// Clock and reset
	input wire clock_i,
	input wire reset_n_i,
	// Sampled level
	input wire level_i,
	// Edge pulses
	output wire rise_o,
	output wire fall_o
);

	reg prev_r;

	// Previous level; starts low so a high pin at release counts as a rise
	always @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= level_i;
		end
	end

	// Pulses compare the current sample with the last one
	assign rise_o = level_i & ~prev_r;
	assign fall_o = ~level_i & prev_r;

endmodule // tcm_edge_detect

`default_nettype wire

// >>> verification/tcm_pin_model.sv
// Far-side model: the source that drives the timer input pin.
// Assumes the bench calls drive just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module tcm_pin_model (
	// Clock
	input wire logic clock_i,
	// Pin into the channel
	output var logic pin_o
);
	initial pin_o = 1'b0;
	// Set a level and hold it; long holds stand for a slow source
	task automatic drive(input logic lvl, input int hold);
		pin_o <= lvl;
		repeat (hold) @(posedge clock_i);
	endtask
endmodule // tcm_pin_model
`default_nettype wire

// >>> verification/tcm_channel_chk.sv
// Checker for the timer channel: read answers, output level control, start.
// Assumes it is bound to tcm_channel and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_defines.vh"
module tcm_chk (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_n_i,
	// Register port
	input wire logic [4:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	// Pins and status
	input wire logic timer_input_pin_i,
	input wire logic [2:0] other_toggle_i,
	input wire logic [3:0] timer_out_o,
	input wire logic timer_irq_o,
	input wire logic running_o
);
	logic [3:0] en_r;
	logic [3:0] mode_r;
	wire lvl_wr = wr_i && addr_i == `TCM_OFS_OUT_LEVEL;
	wire go_wr = wr_i && addr_i == `TCM_OFS_CTRL && wdata_i[1:0] == 2'b01;
	wire stop_wr = wr_i && addr_i == `TCM_OFS_CTRL && wdata_i[1];
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	// Shadows change at the same edge as the design's own registers
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			en_r <= 4'h0;
			mode_r <= 4'h0;
		end else if (wr_i && addr_i == `TCM_OFS_OUT_ENABLE) begin
			en_r <= wdata_i[3:0];
		end else if (wr_i && addr_i == `TCM_OFS_MODE) begin
			mode_r <= wdata_i[3:0];
		end
	end
	a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data outside answer");
	a_level_read: assert property (
		$past(rd_i && addr_i == `TCM_OFS_OUT_LEVEL) |-> rdata_o == {12'h000, $past(timer_out_o)})
		else $error("level read differs from pins");
	a_hold_off: assert property (
		!$past(en_r[1]) && !$past(lvl_wr) |-> $stable(timer_out_o[1])) else $error("disabled output moved");
	a_sw_apply: assert property (
		$past(!en_r[1] && lvl_wr) |-> timer_out_o[1] == $past(wdata_i[1])) else $error("level write lost");
	a_toggle_on: assert property (
		$past(en_r[1] && other_toggle_i[0]) |-> timer_out_o[1] != $past(timer_out_o[1])) else $error("no toggle");
	a_write_ignored: assert property (
		$past(en_r[1] && !other_toggle_i[0]) |-> $stable(timer_out_o[1])) else $error("enabled output written");
	a_start_irq: assert property (
		go_wr && !running_o && (mode_r == 4'h1 || mode_r == 4'h5) |=> timer_irq_o) else $error("no start irq");
	a_start_run: assert property (
		go_wr && mode_r[3:1] == 3'b000 |=> running_o) else $error("interval did not run");
	a_stop_wins: assert property (stop_wr |=> !running_o) else $error("stop ignored");
endmodule // tcm_chk
bind tcm_channel tcm_chk u_chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_input_pin_i(timer_input_pin_i),
	.other_toggle_i(other_toggle_i), .timer_out_o(timer_out_o), .timer_irq_o(timer_irq_o), .running_o(running_o));
`default_nettype wire

// >>> verification/test_timer_channel_mode_and_output.sv
// Bench for the timer channel: registers, modes, retrigger, edges, outputs.
// Assumes the channel, its checker and the pin model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "tcm_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_timer_channel_mode_and_output;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [4:0] addr_i = 5'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [2:0] other_toggle_i = 3'h0;
	wire logic [15:0] rdata_o;
	wire logic [3:0] timer_out_o;
	wire logic timer_irq_o;
	wire logic running_o;
	wire logic pin;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	int k;
	int d;
	int unsigned seed = 90459;
	logic [15:0] v;
	logic [15:0] n;
	logic [3:0] exp_out;
	logic o;
	logic [2:0] opm [5] = '{`TCM_OPM_INTERVAL, `TCM_OPM_CAPTURE, `TCM_OPM_ONECOUNT, `TCM_OPM_EVENT, `TCM_OPM_WIDTH};
	tcm_channel uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .timer_input_pin_i(pin), .other_toggle_i(other_toggle_i),
		.timer_out_o(timer_out_o), .timer_irq_o(timer_irq_o), .running_o(running_o));
	tcm_pin_model pm (.clock_i(clock_i), .pin_o(pin));
	always #5 clock_i = ~clock_i;
	// A hang counts as a failure
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tick(input int t);
		repeat (t) @(posedge clock_i);
		#1;
	endtask
	// Strobes drop on the taking edge; the #1 keeps the next task off that step
	task automatic wr(input logic [4:0] a, input logic [15:0] dat);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= dat;
		@(posedge clock_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] q);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		q = rdata_o;
	endtask
	task automatic wirq(output int c);
		c = 0;
		while (timer_irq_o !== 1'b1 && c < 300) begin
			tick(1);
			c++;
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock_i);
		reset_n_i <= 1'b1;
		#1;
		// Cleared registers; unmapped place ignores writes
		wr(5'h1C, 16'hFFFF);
		for (k = 0; k < 8; k++) begin
			rd(5'(k * 4), v);
			`CHK(v, 16'h0000)
		end
		// Random legal mode words read back
		for (k = 0; k < 12; k++) begin
			d = rnd() % 5;
			n = 16'(rnd());
			v = {4'h0, n[11], 3'h0, n[7:6], 2'h0, opm[d], n[0] & (d < 3)};
			wr(`TCM_OFS_MODE, v);
			rd(`TCM_OFS_MODE, n);
			`CHK(n, v)
		end
		// Interval: first irq and period, both widths, both start options
		for (k = 0; k < 4; k++) begin
			n = 16'(3 + rnd() % 8) | (k > 1 ? 16'h5A00 : 16'h0000);
			wr(`TCM_OFS_COUNT_VALUE, n);
			wr(`TCM_OFS_OUT_ENABLE, 16'h0001);
			wr(`TCM_OFS_MODE, 16'(k > 1) << 11 | 16'(k % 2));
			wr(`TCM_OFS_CTRL, 16'h0001);
			wirq(d);
			`CHK(d, k % 2 ? 0 : n[7:0] + 1)
			o = timer_out_o[0];
			tick(1);
			wirq(d);
			`CHK(d, n[7:0])
			`CHK(timer_out_o[0], ~o)
			wr(`TCM_OFS_CTRL, 16'h0002);
		end
		// Capture counts up from zero
		wr(`TCM_OFS_MODE, 16'h0044);
		wr(`TCM_OFS_CTRL, 16'h0001);
		rd(`TCM_OFS_COUNTER, v);
		`CHK(v, 16'h0000)
		rd(`TCM_OFS_COUNTER, v);
		`CHK(v, 16'h0001)
		// A rising edge copies the running count into the count value
		pm.drive(1'b1, 2);
		pm.drive(1'b0, 1);
		rd(`TCM_OFS_COUNT_VALUE, v);
		`CHK(v, 16'h0002)
		wr(`TCM_OFS_CTRL, 16'h0002);
		// One-count with a retrigger in mid-count
		for (k = 0; k < 2; k++) begin
			wr(`TCM_OFS_COUNT_VALUE, 16'h000C);
			wr(`TCM_OFS_MODE, 16'h0008 | 16'(k));
			wr(`TCM_OFS_CTRL, 16'h0001);
			rd(`TCM_OFS_COUNTER, v);
			`CHK(v, 16'h000C)
			tick(3);
			wr(`TCM_OFS_CTRL, 16'h0001);
			d = 0;
			repeat (40) begin
				d += timer_irq_o;
				tick(1);
			end
			`CHK(d, k + 1)
			`CHK(running_o, 1'b0)
		end
		// Event counting on rising pin edges
		wr(`TCM_OFS_MODE, 16'h0046);
		wr(`TCM_OFS_COUNT_VALUE, 16'h0009);
		wr(`TCM_OFS_CTRL, 16'h0001);
		repeat (3) begin
			pm.drive(1'b1, 3);
			pm.drive(1'b0, 3);
		end
		tick(0);
		rd(`TCM_OFS_COUNTER, v);
		`CHK(v, 16'h0006)
		wr(`TCM_OFS_CTRL, 16'h0002);
		// Every edge code: pin-started one-count, then level width
		for (k = 0; k < 4; k++) begin
			wr(`TCM_OFS_MODE, (k < 2 ? 16'h0008 : 16'h000C) | 16'(k) << 6);
			wr(`TCM_OFS_COUNT_VALUE, 16'h0014);
			wr(`TCM_OFS_CTRL, k < 2 ? 16'h0004 : 16'h0001);
			rd(`TCM_OFS_CTRL, v);
			`CHK(v, k < 2 ? 16'h0004 : 16'h0010)
			pm.drive(1'b1, 5);
			tick(0);
			`CHK(running_o, k[0])
			pm.drive(1'b0, 5);
			tick(0);
			`CHK(running_o, k != 3)
			wr(`TCM_OFS_CTRL, 16'h0002);
		end
		// Random enables, writes and toggles on the level register
		wr(`TCM_OFS_OUT_ENABLE, 16'h0000);
		wr(`TCM_OFS_OUT_LEVEL, 16'h0000);
		exp_out = 4'h0;
		for (k = 0; k < 30; k++) begin
			n = 16'(rnd());
			wr(`TCM_OFS_OUT_ENABLE, {12'h000, n[3:0]});
			wr(`TCM_OFS_OUT_LEVEL, {12'h000, n[7:4]});
			exp_out = (exp_out & n[3:0]) | (n[7:4] & ~n[3:0]);
			other_toggle_i <= n[10:8];
			@(posedge clock_i);
			other_toggle_i <= 3'h0;
			#1;
			exp_out = exp_out ^ ({n[10:8], 1'b0} & n[3:0]);
			`CHK(timer_out_o, exp_out)
		end
		print_verdict();
	end
endmodule // test_timer_channel_mode_and_output
`default_nettype wire
